/* File: src/lss_sequencer.sv */
// Lamp ballast start-up sequencer: reset, start-up, preheat, ignition, burn, hold, power-down
//
// Notes on behaviour
// [RULE_01] Below reset level: hold cleared, switches off
// [RULE_02] Above reset level enters start-up; else reset
// [RULE_03] Start-up: high switch off, low on
// [RULE_04] High gate zero while floating supply low
// [RULE_05] Oscillate from start level, at maximum frequency
// [RULE_06] Timing cap above upper level enters preheat
// [RULE_07] Oscillate only between stop and clamp levels
// [RULE_08] Preheat lowers frequency until sense reaches level
// [RULE_09] Preheat lasts eight timing saw-tooth periods
// [RULE_10] Lamp current feedback off during preheat
// [RULE_11] Low switch sense filtered for 30 ns
// [RULE_12] Supply below stop in preheat enters hold
// [RULE_13] Repeat preheat needs release, then upper crossing
// [RULE_14] Preheat done: ignition, fixed-current downward sweep
// [RULE_15] Current sense above 0.6 V means ignition
// [RULE_16] Without ignition, sweep continues to minimum
// [RULE_17] At most two ignition attempts per power-up
// [RULE_18] Count failed windows only, not supply drops
// [RULE_19] Ignition window is quarter of preheat
// [RULE_20] Second failed attempt enters power-down
// [RULE_21] Power-down level, long overcurrent, capacitive fault
// [RULE_22] Hold: latch set, oscillator off, low on
// [RULE_23] Hold leaves on release level or reset
// [RULE_24] Comparator inputs synchronised to the controller clock
`timescale 1ns/1ps
module lss_sequencer
    import lss_pkg::*;
#(
    parameter int unsigned TEETH_PREHEAT = PREHEAT_TEETH,
    parameter int unsigned TEETH_IGN     = IGN_WINDOW_TEETH,
    parameter int unsigned ATTEMPTS      = MAX_IGN_ATTEMPTS,
    parameter int unsigned FILTER_CYC    = SENSE_FILTER_CYC
) (
    input  wire logic                 ref_clk,
    input  wire logic                 nrst,
    input  wire logic                 supply_above_reset,
    input  wire logic                 supply_above_start,
    input  wire logic                 supply_above_stop,
    input  wire logic                 supply_above_clamp,
    input  wire logic                 floating_supply_ok,
    input  wire logic                 timing_cap_above_upper,
    input  wire logic                 timing_cap_below_release,
    input  wire logic                 timing_cap_below_powerdown,
    input  wire logic                 low_switch_sense_at_level,
    input  wire logic                 current_sense_ignition,
    input  wire logic                 overcurrent_detect,
    input  wire logic                 capacitive_at_max_freq,
    input  wire logic                 oscillator_phase_high,
    output logic                      high_gate_drive,
    output logic                      low_gate_drive,
    output logic                      oscillator_enable,
    output logic                      vco_hold_max_freq,
    output logic                      vco_preheat_charge,
    output logic                      vco_sweep_charge,
    output logic                      current_feedback_enable,
    output logic                      hold_latch,
    output logic                      lamp_ignited,
    output logic                      power_down,
    output logic [ATTEMPT_W-1:0]      ignition_attempts,
    output logic [2:0]                sequencer_state
);

    localparam int unsigned NSYNC = 12;

    // Overcurrent time exceeds the fraction of the preheat time
    function automatic logic oc_exceeds(input logic [PERIOD_CNT_W-1:0] oc_len,
                                        input logic [PERIOD_CNT_W-1:0] tooth_len);
        logic [PERIOD_CNT_W+7:0] lhs;
        logic [PERIOD_CNT_W+7:0] rhs;
        lhs = (PERIOD_CNT_W+8)'(oc_len) * (PERIOD_CNT_W+8)'(OC_FRAC_DEN);
        rhs = (PERIOD_CNT_W+8)'(tooth_len) * (PERIOD_CNT_W+8)'(TEETH_PREHEAT * OC_FRAC_NUM);
        return lhs > rhs;
    endfunction

    logic [NSYNC-1:0] raw_vec;
    logic [NSYNC-1:0] syn_vec;
    logic             rst_ok_s;
    logic             start_s;
    logic             stop_s;
    logic             clamp_s;
    logic             fs_ok_s;
    logic             upper_s;
    logic             release_s;
    logic             pd_s;
    logic             sense_s;
    logic             ign_s;
    logic             oc_s;
    logic             capmode_s;
    logic             sense_f;

    assign raw_vec = {supply_above_reset, supply_above_start, supply_above_stop,
                      supply_above_clamp, floating_supply_ok, timing_cap_above_upper,
                      timing_cap_below_release, timing_cap_below_powerdown,
                      low_switch_sense_at_level, current_sense_ignition,
                      overcurrent_detect, capacitive_at_max_freq};

    lss_sync #(
        .WIDTH (NSYNC)
    ) u_sync (
        .ref_clk  (ref_clk),
        .nrst     (nrst),
        .async_in (raw_vec),
        .sync_out (syn_vec)
    ); // RULE_24

    assign {rst_ok_s, start_s, stop_s, clamp_s, fs_ok_s, upper_s,
            release_s, pd_s, sense_s, ign_s, oc_s, capmode_s} = syn_vec;

    lss_glitch_filter #(
        .CYCLES (FILTER_CYC)
    ) u_sense_filt (
        .ref_clk  (ref_clk),
        .nrst     (nrst),
        .raw_in   (sense_s),
        .filt_out (sense_f)
    ); // RULE_11

    lss_state_e                  state_q;
    lss_state_e                  state_d;
    logic                        upper_prev_q;
    logic                        tooth;
    logic [TOOTH_CNT_W-1:0]      teeth_q;
    logic [ATTEMPT_W-1:0]        attempts_q;
    logic                        hold_q;
    logic                        osc_run_q;
    logic                        osc_ok;
    logic                        released_q;
    logic [PERIOD_CNT_W-1:0]     period_cnt_q;
    logic [PERIOD_CNT_W-1:0]     period_len_q;
    logic [PERIOD_CNT_W-1:0]     oc_cnt_q;
    logic                        fault;
    logic                        ign_window_end;
    logic                        preheat_done;

    // Each rising crossing of the upper level closes one saw-tooth period
    assign tooth = upper_s & ~upper_prev_q;
    assign osc_ok = stop_s & ~clamp_s; // RULE_07
    assign preheat_done = tooth && (teeth_q == TOOTH_CNT_W'(TEETH_PREHEAT - 1)); // RULE_09
    assign ign_window_end = tooth && (teeth_q == TOOTH_CNT_W'(TEETH_IGN - 1)); // RULE_19

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            upper_prev_q <= 1'b0;
        end else begin
            upper_prev_q <= upper_s;
        end
    end

    // Fault conditions that end in power-down
    always_comb begin
        fault = 1'b0;
        if (state_q == LSS_PREHEAT || state_q == LSS_IGNITION || state_q == LSS_BURN) begin
            fault = pd_s; // RULE_21
        end
        if (state_q == LSS_BURN) begin
            fault = fault | capmode_s | oc_exceeds(oc_cnt_q, period_len_q); // RULE_21
        end
    end

    // State transitions; loss of the reset level overrides everything
    always_comb begin
        state_d = state_q;
        if (!rst_ok_s) begin
            state_d = LSS_RESET; // RULE_01 RULE_02
        end else begin
            case (state_q)
                LSS_RESET: begin
                    state_d = LSS_STARTUP; // RULE_02
                end
                LSS_STARTUP: begin
                    if (osc_run_q && osc_ok && start_s && tooth && released_q) begin
                        state_d = LSS_PREHEAT; // RULE_06 RULE_13
                    end
                end
                LSS_PREHEAT: begin
                    if (fault) begin
                        state_d = LSS_POWERDOWN; // RULE_21
                    end else if (!stop_s) begin
                        state_d = LSS_HOLD; // RULE_12
                    end else if (preheat_done) begin
                        state_d = LSS_IGNITION; // RULE_14
                    end
                end
                LSS_IGNITION: begin
                    if (fault) begin
                        state_d = LSS_POWERDOWN; // RULE_21
                    end else if (ign_s) begin
                        state_d = LSS_BURN; // RULE_15
                    end else if (!stop_s) begin
                        state_d = LSS_HOLD; // RULE_18
                    end else if (ign_window_end) begin
                        if (attempts_q == ATTEMPT_W'(ATTEMPTS - 1)) begin
                            state_d = LSS_POWERDOWN; // RULE_20
                        end else begin
                            state_d = LSS_HOLD;
                        end
                    end
                end
                LSS_BURN: begin
                    if (fault) begin
                        state_d = LSS_POWERDOWN; // RULE_21
                    end
                end
                LSS_HOLD: begin
                    if (release_s) begin
                        state_d = LSS_STARTUP; // RULE_23
                    end
                end
                LSS_POWERDOWN: begin
                    state_d = LSS_POWERDOWN;
                end
                default: begin
                    state_d = LSS_RESET;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            state_q <= LSS_RESET;
        end else begin
            state_q <= state_d;
        end
    end

    // Saw-tooth counter, restarted on every entry to a timed state
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            teeth_q <= '0;
        end else if (state_d != state_q) begin
            teeth_q <= '0;
        end else if (tooth) begin
            teeth_q <= teeth_q + TOOTH_CNT_W'(1);
        end
    end

    // Attempts survive hold but are cleared by each power-up
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            attempts_q <= '0;
        end else if (state_q == LSS_RESET) begin
            attempts_q <= '0; // RULE_17
        end else if (state_q == LSS_IGNITION && !ign_s && stop_s && !fault
                     && ign_window_end) begin
            attempts_q <= attempts_q + ATTEMPT_W'(1); // RULE_18
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            hold_q <= 1'b0;
        end else if (state_q == LSS_RESET) begin
            hold_q <= 1'b0; // RULE_01
        end else if (state_q == LSS_HOLD) begin
            hold_q <= 1'b1; // RULE_22
        end
    end

    // A retry needs the timing cap to have passed the release level first
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            released_q <= 1'b1;
        end else if (state_q == LSS_RESET) begin
            released_q <= 1'b1;
        end else if (state_q == LSS_HOLD) begin
            released_q <= release_s; // RULE_13
        end
    end

    // Oscillator arms at the start level and stops outside stop..clamp
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            osc_run_q <= 1'b0;
        end else if (state_d == LSS_RESET || state_d == LSS_HOLD
                     || state_d == LSS_POWERDOWN) begin
            osc_run_q <= 1'b0; // RULE_22
        end else if (!osc_ok) begin
            osc_run_q <= 1'b0; // RULE_07
        end else if (state_q == LSS_STARTUP && start_s) begin
            osc_run_q <= 1'b1; // RULE_05
        end
    end

    // Last saw-tooth period length, the base for the overcurrent time
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            period_cnt_q <= '0;
            period_len_q <= '1;
        end else if (tooth) begin
            period_cnt_q <= '0;
            period_len_q <= period_cnt_q;
        end else if (period_cnt_q != '1) begin
            period_cnt_q <= period_cnt_q + PERIOD_CNT_W'(1);
        end
    end

    // Only a continuous overcurrent accumulates time
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            oc_cnt_q <= '0;
        end else if (state_q != LSS_BURN || !oc_s) begin
            oc_cnt_q <= '0;
        end else if (oc_cnt_q != '1) begin
            oc_cnt_q <= oc_cnt_q + PERIOD_CNT_W'(1);
        end
    end

    // Registered outputs; gate drives follow the oscillator phase a cycle late
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            high_gate_drive         <= 1'b0;
            low_gate_drive          <= 1'b0;
            oscillator_enable       <= 1'b0;
            vco_hold_max_freq       <= 1'b1;
            vco_preheat_charge      <= 1'b0;
            vco_sweep_charge        <= 1'b0;
            current_feedback_enable <= 1'b0;
            lamp_ignited            <= 1'b0;
            power_down              <= 1'b0;
        end else begin
            oscillator_enable <= osc_run_q & osc_ok;
            vco_hold_max_freq <= (state_q == LSS_STARTUP) || !osc_run_q; // RULE_05
            vco_preheat_charge <= (state_q == LSS_PREHEAT) & ~sense_f; // RULE_08
            vco_sweep_charge <= (state_q == LSS_IGNITION); // RULE_14 RULE_16
            current_feedback_enable <= (state_q == LSS_BURN); // RULE_10
            lamp_ignited <= (state_q == LSS_BURN);
            power_down <= (state_q == LSS_POWERDOWN);
            case (state_q)
                LSS_RESET, LSS_POWERDOWN: begin
                    high_gate_drive <= 1'b0; // RULE_01
                    low_gate_drive  <= 1'b0;
                end
                LSS_HOLD: begin
                    high_gate_drive <= 1'b0; // RULE_22
                    low_gate_drive  <= 1'b1;
                end
                default: begin
                    if (osc_run_q && osc_ok && state_q != LSS_STARTUP) begin
                        high_gate_drive <= oscillator_phase_high & fs_ok_s; // RULE_04
                        low_gate_drive  <= ~oscillator_phase_high;
                    end else if (osc_run_q && osc_ok) begin
                        high_gate_drive <= oscillator_phase_high & fs_ok_s; // RULE_04
                        low_gate_drive  <= ~oscillator_phase_high;
                    end else begin
                        high_gate_drive <= 1'b0; // RULE_03
                        low_gate_drive  <= 1'b1;
                    end
                end
            endcase
        end
    end

    assign hold_latch        = hold_q;
    assign ignition_attempts = attempts_q;
    assign sequencer_state   = state_q;

endmodule

/* File: src/lss_pkg.sv */
// Constants and state type for the lamp start-up sequencer
package lss_pkg;

    // Saw-tooth periods on the timing capacitor
    localparam int unsigned PREHEAT_TEETH    = 8;
    localparam int unsigned IGN_WINDOW_TEETH = PREHEAT_TEETH / 4;
    localparam int unsigned TOOTH_CNT_W      = 4;

    // Ignition attempts allowed after each power-up
    localparam int unsigned MAX_IGN_ATTEMPTS = 2;
    localparam int unsigned ATTEMPT_W        = 2;

    // Overcurrent fault time as a fraction of the preheat time
    localparam int unsigned OC_FRAC_NUM      = 1;
    localparam int unsigned OC_FRAC_DEN      = 10;

    // Clock and sense filter timing
    localparam int unsigned CLK_PERIOD_NS    = 10;
    localparam int unsigned SENSE_FILTER_NS  = 30;
    localparam int unsigned SENSE_FILTER_CYC =
        (SENSE_FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Saw-tooth period measurement and synchroniser stages
    localparam int unsigned PERIOD_CNT_W     = 24;
    localparam int unsigned SYNC_STAGES      = 2;

    typedef enum logic [2:0] {
        LSS_RESET,
        LSS_STARTUP,
        LSS_PREHEAT,
        LSS_IGNITION,
        LSS_BURN,
        LSS_HOLD,
        LSS_POWERDOWN
    } lss_state_e;

endpackage

/* File: src/lss_sync.sv */
// Two-stage synchroniser bank for comparator inputs
`timescale 1ns/1ps
module lss_sync
    import lss_pkg::*;
#(
    parameter int unsigned WIDTH = 1
) (
    input  wire logic             ref_clk,
    input  wire logic             nrst,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta_q;

    // The first stage feeds only the second stage
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            meta_q   <= '0;
            sync_out <= '0;
        end else begin
            meta_q   <= async_in;
            sync_out <= meta_q;
        end
    end

endmodule

/* File: src/lss_glitch_filter.sv */
// Glitch filter: output follows input once stable for CYCLES clocks
`timescale 1ns/1ps
module lss_glitch_filter
    import lss_pkg::*;
#(
    parameter int unsigned CYCLES = SENSE_FILTER_CYC
) (
    input  wire logic ref_clk,
    input  wire logic nrst,
    input  wire logic raw_in,
    output logic      filt_out
);

    localparam int unsigned CW = $clog2(CYCLES + 1);

    logic [CW-1:0] stable_q;

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            stable_q <= '0;
            filt_out <= 1'b0;
        end else if (raw_in == filt_out) begin
            stable_q <= '0;
        end else if (stable_q == CW'(CYCLES - 1)) begin
            stable_q <= '0;
            filt_out <= raw_in;
        end else begin
            stable_q <= stable_q + CW'(1);
        end
    end

endmodule

/* File: test/lss_checker.sv */
// Port assertions for the lamp start-up sequencer
`timescale 1ns/1ps
module lss_checker
    import lss_pkg::*;
#(
    parameter int unsigned ATTEMPTS = MAX_IGN_ATTEMPTS
) (
    input wire logic       ref_clk,
    input wire logic       nrst,
    input wire logic       supply_above_reset,
    input wire logic       supply_above_stop,
    input wire logic       supply_above_clamp,
    input wire logic       floating_supply_ok,
    input wire logic       high_gate_drive,
    input wire logic       low_gate_drive,
    input wire logic       oscillator_enable,
    input wire logic       vco_hold_max_freq,
    input wire logic       vco_sweep_charge,
    input wire logic       current_feedback_enable,
    input wire logic       hold_latch,
    input wire logic [1:0] ignition_attempts,
    input wire logic [2:0] sequencer_state
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!nrst);

    // Five cycles cover the synchroniser plus the registered outputs
    chk_reset_force: assert property (
        !supply_above_reset [*5] |=> sequencer_state == 3'h0 && !hold_latch
            && !high_gate_drive && !low_gate_drive) else $error("reset level ignored");
    chk_hold_outputs: assert property (
        sequencer_state == 3'h5 |=> hold_latch && !oscillator_enable && !high_gate_drive
            && low_gate_drive) else $error("hold outputs wrong");
    chk_float_lockout: assert property (
        !floating_supply_ok [*5] |-> !high_gate_drive) else $error("high gate in lockout");
    chk_osc_window: assert property (
        (!supply_above_stop || supply_above_clamp) [*5] |=> !oscillator_enable)
        else $error("oscillator outside supply window");
    chk_osc_max_start: assert property (
        $rose(oscillator_enable) |-> vco_hold_max_freq) else $error("start not at max");
    chk_preheat_nofb: assert property (
        sequencer_state == 3'h2 |=> !current_feedback_enable) else $error("feedback on");
    chk_preheat_entry: assert property (
        sequencer_state == 3'h2 && $past(sequencer_state) != 3'h2
            |-> $past(sequencer_state) == 3'h1) else $error("bad preheat entry");
    chk_ignition_sweep: assert property (
        sequencer_state == 3'h3 && $past(sequencer_state) != 3'h3
            |-> $past(sequencer_state) == 3'h2 ##1 vco_sweep_charge)
        else $error("bad ignition entry");
    chk_attempt_step: assert property (
        ignition_attempts != $past(ignition_attempts) && ignition_attempts != 2'h0
            |-> ignition_attempts == $past(ignition_attempts) + 2'h1
            && ($past(sequencer_state) == 3'h3 || $past(sequencer_state, 2) == 3'h3))
        else $error("attempt count step wrong");
    chk_attempts_max: assert property (
        ignition_attempts <= ATTEMPTS) else $error("too many attempts");
endmodule

bind lss_sequencer lss_checker #(.ATTEMPTS(ATTEMPTS)) u_lss_checker (
    .ref_clk(ref_clk), .nrst(nrst), .supply_above_reset(supply_above_reset),
    .supply_above_stop(supply_above_stop), .supply_above_clamp(supply_above_clamp),
    .floating_supply_ok(floating_supply_ok), .high_gate_drive(high_gate_drive),
    .low_gate_drive(low_gate_drive), .oscillator_enable(oscillator_enable),
    .vco_hold_max_freq(vco_hold_max_freq), .vco_sweep_charge(vco_sweep_charge),
    .current_feedback_enable(current_feedback_enable), .hold_latch(hold_latch),
    .ignition_attempts(ignition_attempts), .sequencer_state(sequencer_state));

/* File: test/lss_partner.sv */
// Behavioural model of the oscillator, timing capacitor and sense comparator
`timescale 1ns/1ps
module lss_partner #(
    parameter int TOOTH = 20
) (
    input  wire logic ref_clk,
    input  wire logic run,
    input  wire logic oscillator_enable,
    input  wire logic vco_preheat_charge,
    output logic      timing_cap_above_upper,
    output logic      oscillator_phase_high,
    output logic      low_switch_sense_at_level
);
    int tooth_cnt;
    int charge_cnt;

    initial begin
        tooth_cnt = 0;
        charge_cnt = 0;
        timing_cap_above_upper = 1'b0;
        oscillator_phase_high = 1'b0;
        low_switch_sense_at_level = 1'b0;
    end

    always @(negedge ref_clk) begin
        // Timer stopped keeps the saw-tooth below its upper level
        tooth_cnt = run ? (tooth_cnt + 1) % TOOTH : 0;
        timing_cap_above_upper <= run && tooth_cnt >= TOOTH / 2;
        oscillator_phase_high <= oscillator_enable && !oscillator_phase_high;
        // Sense grows only while the integrator keeps lowering the frequency
        charge_cnt = vco_preheat_charge ? charge_cnt + 1 : 0;
        low_switch_sense_at_level <= charge_cnt > 6;
    end
endmodule

/* File: test/test_lss_sequencer.sv */
// Self-checking testbench for the lamp start-up sequencer
`timescale 1ns/1ps
module test_lss_sequencer
    import lss_pkg::*;
;
    logic       ref_clk, nrst, tooth_run, hs_seen, supply_above_clamp;
    logic       supply_above_reset, supply_above_start, supply_above_stop;
    logic       floating_supply_ok, timing_cap_below_release, timing_cap_below_powerdown;
    logic       current_sense_ignition, timing_cap_above_upper, oscillator_phase_high;
    logic       low_switch_sense_at_level, high_gate_drive, low_gate_drive;
    logic       oscillator_enable, vco_hold_max_freq, vco_preheat_charge, vco_sweep_charge;
    logic       current_feedback_enable, hold_latch, lamp_ignited, power_down;
    logic [1:0] ignition_attempts;
    logic [2:0] sequencer_state;
    int         error_cnt, total_checks, teeth;

    lss_sequencer u_lss_sequencer (
        .ref_clk(ref_clk), .nrst(nrst), .supply_above_reset(supply_above_reset),
        .supply_above_start(supply_above_start), .supply_above_stop(supply_above_stop),
        .supply_above_clamp(supply_above_clamp), .floating_supply_ok(floating_supply_ok),
        .timing_cap_above_upper(timing_cap_above_upper),
        .timing_cap_below_release(timing_cap_below_release),
        .timing_cap_below_powerdown(timing_cap_below_powerdown),
        .low_switch_sense_at_level(low_switch_sense_at_level),
        .current_sense_ignition(current_sense_ignition), .overcurrent_detect(1'b0),
        .capacitive_at_max_freq(1'b0), .oscillator_phase_high(oscillator_phase_high),
        .high_gate_drive(high_gate_drive), .low_gate_drive(low_gate_drive),
        .oscillator_enable(oscillator_enable), .vco_hold_max_freq(vco_hold_max_freq),
        .vco_preheat_charge(vco_preheat_charge), .vco_sweep_charge(vco_sweep_charge),
        .current_feedback_enable(current_feedback_enable), .hold_latch(hold_latch),
        .lamp_ignited(lamp_ignited), .power_down(power_down),
        .ignition_attempts(ignition_attempts), .sequencer_state(sequencer_state));

    lss_partner u_lss_partner (
        .ref_clk(ref_clk), .run(tooth_run), .oscillator_enable(oscillator_enable),
        .vco_preheat_charge(vco_preheat_charge),
        .timing_cap_above_upper(timing_cap_above_upper),
        .oscillator_phase_high(oscillator_phase_high),
        .low_switch_sense_at_level(low_switch_sense_at_level));

    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    always @(posedge timing_cap_above_upper) teeth++;
    always @(posedge high_gate_drive) hs_seen = 1'b1;

    task automatic chk_val(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Bounded wait so a stuck state machine shows up as a mismatch
    task automatic wait_state(input logic [2:0] s);
        int n;
        n = 0;
        while (sequencer_state !== s && n < 3000) begin
            @(negedge ref_clk);
            n++;
        end
        chk_val(sequencer_state, s);
    endtask

    task automatic settle();
        repeat (4) @(negedge ref_clk);
    endtask

    task automatic t_reset_startup();
        chk_val(sequencer_state, 8'h00);
        chk_val({vco_hold_max_freq, high_gate_drive, low_gate_drive}, 8'h04);
        supply_above_reset = 1'b1;
        wait_state(3'h1);
        settle();
        chk_val({oscillator_enable, high_gate_drive, low_gate_drive}, 8'h01);
        $display("test reset_startup done");
    endtask

    task automatic t_ignition_fail();
        supply_above_start = 1'b1;
        repeat (8) @(negedge ref_clk);
        chk_val({oscillator_enable, vco_hold_max_freq}, 8'h03);
        supply_above_clamp = 1'b1;
        repeat (6) @(negedge ref_clk);
        chk_val(oscillator_enable, 8'h00);
        supply_above_clamp = 1'b0;
        tooth_run = 1'b1;
        wait_state(3'h2);
        teeth = 0;
        settle();
        chk_val(vco_preheat_charge, 8'h01);
        wait_state(3'h3);
        chk_val(teeth, 8'h08);
        teeth = 0;
        wait_state(3'h5);
        chk_val(teeth, 8'h02);
        chk_val(ignition_attempts, 8'h01);
        chk_val(hs_seen, 8'h01);
        settle();
        chk_val({hold_latch, high_gate_drive, low_gate_drive}, 8'h05);
        tooth_run = 1'b0;
        timing_cap_below_release = 1'b1;
        wait_state(3'h1);
        timing_cap_below_release = 1'b0;
        tooth_run = 1'b1;
        wait_state(3'h2);
        wait_state(3'h6);
        settle();
        chk_val({power_down, ignition_attempts}, 8'h06);
        $display("test ignition_fail done");
    endtask

    task automatic t_drop_and_burn();
        supply_above_reset = 1'b0;
        tooth_run = 1'b0;
        floating_supply_ok = 1'b0;
        wait_state(3'h0);
        settle();
        chk_val({hold_latch, ignition_attempts}, 8'h00);
        supply_above_reset = 1'b1;
        wait_state(3'h1);
        tooth_run = 1'b1;
        wait_state(3'h2);
        supply_above_stop = 1'b0;
        wait_state(3'h5);
        chk_val(ignition_attempts, 8'h00);
        supply_above_stop = 1'b1;
        tooth_run = 1'b0;
        timing_cap_below_release = 1'b1;
        wait_state(3'h1);
        timing_cap_below_release = 1'b0;
        tooth_run = 1'b1;
        wait_state(3'h3);
        current_sense_ignition = 1'b1;
        wait_state(3'h4);
        settle();
        chk_val({lamp_ignited, current_feedback_enable, high_gate_drive}, 8'h06);
        timing_cap_below_powerdown = 1'b1;
        wait_state(3'h6);
        $display("test drop_and_burn done");
    endtask

    task automatic complete_run();
        $display("checks=%0d errors=%0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    initial begin
        {nrst, tooth_run, hs_seen, supply_above_reset, supply_above_start} = 5'h00;
        {timing_cap_below_release, timing_cap_below_powerdown, supply_above_clamp} = 3'h0;
        current_sense_ignition = 1'b0;
        supply_above_stop = 1'b1;
        floating_supply_ok = 1'b1;
        error_cnt = 0;
        total_checks = 0;
        teeth = 0;
        repeat (20) @(negedge ref_clk);
        nrst = 1'b1;
        @(negedge ref_clk);
        t_reset_startup();
        t_ignition_fail();
        t_drop_and_burn();
        complete_run();
    end

    // Whole run is under a thousand cycles; this leaves ample margin
    initial begin
        #200000;
        error_cnt++;
        complete_run();
    end
endmodule
